// [clock_safeguard_defines.svh]
// offsets, field positions, reset values and timing counts of the clock block
// assumes the including file sits in the same folder
`ifndef CLOCK_SAFEGUARD_DEFINES_SVH
`define CLOCK_SAFEGUARD_DEFINES_SVH

`define MCLK_PERIOD_NS 50
`define SG_MIN_PERIOD_NS 125
`define SG_MIN_CYCLES ((`SG_MIN_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define BACKUP_PERIOD_NS 2000
`define BACKUP_TIMEOUT_CYCLES ((`BACKUP_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define STARTUP_SHORT_CYCLES 2048
`define STARTUP_LONG_CYCLES 32768
`define PERIPH_DIVIDE 12
`define CPU_DIVIDE 13

`define ADDR_CONV_CTRL 8'hD1
`define ADDR_DIV_CTRL 8'hDC
`define ADDR_STATUS 8'hDF
`define OSC_STOP_BIT 2
`define CONV_CTRL_RESET 8'h00
`define DIV_CTRL_RESET 2'h0
`define STAT_ON_BACKUP 0
`define STAT_MAIN_RUN 1
`define STAT_STARTING 2
`define STAT_SG_ON 3

`endif

// [clock_safeguard_pkg.sv]
// types shared by the clock safeguard and divider block
// assumes nothing beyond the defines header
package clock_safeguard_pkg;

  typedef enum logic [1:0] {
    ST_STARTING,
    ST_ALIGN,
    ST_RUN_MAIN,
    ST_RUN_BACKUP
  } clk_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : clock_safeguard_pkg

// [edge_sync.sv]
// two-flop synchroniser with rising edge detect, one bit per lane
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps

module edge_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins
  input wire logic [W-1:0] pin,
  // synchronised level and edge
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
      rise <= '0;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
      rise <= level & ~prev;
    end
  end

endmodule : edge_sync

// [tick_divider.sv]
// enable-pulse divider with a run-time ratio
// assumes en is a one-cycle pulse on mclk; ratio of zero acts as one
`timescale 1ns/1ps

module tick_divider #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // input pulses and ratio
  input wire logic en,
  input wire logic [W-1:0] ratio,
  // divided pulse
  output logic tick
);

  logic [W-1:0] cnt;
  logic wrap;

  assign wrap = (ratio == '0) || (cnt >= ratio - 1'b1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= en && wrap;
      if (en) begin
        if (wrap) begin
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

endmodule : tick_divider

// [clock_safeguard.sv]
// clock safeguard, backup oscillator switch and internal clock dividers
// assumes oscillator pins and option straps are asynchronous to mclk,
// and a register port master on mclk with one-cycle strobes
`timescale 1ns/1ps
`include "clock_safeguard_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - timer, converter, watchdog tick: internal divided by twelve
// - cpu machine cycle: internal clock divided by thirteen
// - stop control is bit 2 at D1h
// - stop with safeguard: main off, backup on
// - main restarts on stop cleared or reset
// - stay on backup through startup and instruction
// - backup starts one period after missing edge
// - backup clock drives everything, only slower
// - power-on delay counter fed by backup first
// - backup off once main has finished startup delay and cpu alignment
// - safeguard limits rate, removes spike edges
// - too fast input: drop cycles to stay below limit
// - safeguard enabled by option, not register
// - option picks crystal input or resistor oscillator
// - divider control write-only at DCh, reset 00h
// - ratio code 00:1, 01:2, 1x:4
// - startup delay 2048 or 32768 oscillator cycles
// - safeguard option high enables, low disables
module clock_safeguard
  import clock_safeguard_pkg::*;
#(
  parameter int STARTUP_SHORT = `STARTUP_SHORT_CYCLES,
  parameter int STARTUP_LONG = `STARTUP_LONG_CYCLES,
  parameter int SG_MIN = `SG_MIN_CYCLES,
  parameter int BACKUP_TIMEOUT = `BACKUP_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire clock_safeguard_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // oscillator pins
  input wire logic xtal_osc_in,
  input wire logic rc_osc_in,
  input wire logic backup_osc_in,
  output logic main_osc_en,
  output logic backup_osc_en,
  // option straps
  input wire logic safeguard_enable_option,
  input wire logic osc_type_option,
  input wire logic delay_option,
  // converter control bits
  output logic [7:0] converter_control_reg,
  // clock enables and state
  output logic int_tick,
  output logic cpu_tick,
  output logic periph_tick,
  output logic on_backup,
  output logic por_delay_done
);

  import clock_safeguard_pkg::*;

  function automatic logic [3:0] decode_ratio(input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h4;
    if (sel == 2'h0) begin
      r = 4'h1;
    end else if (sel == 2'h1) begin
      r = 4'h2;
    end
    return r;
  endfunction : decode_ratio

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [2:0] osc_level;
  logic [2:0] osc_rise;
  logic [2:0] opt_level;

  edge_sync #(.W(3)) u_osc_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({backup_osc_in, rc_osc_in, xtal_osc_in}),
    .level(osc_level),
    .rise(osc_rise)
  );

  edge_sync #(.W(3)) u_opt_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({delay_option, osc_type_option, safeguard_enable_option}),
    .level(opt_level),
    .rise()
  );

  logic sg_on;
  logic rc_sel;
  logic long_delay;
  logic main_raw_edge;
  logic backup_edge;

  assign sg_on = opt_level[0];
  assign rc_sel = opt_level[1];
  assign long_delay = opt_level[2];
  assign main_raw_edge = rc_sel ? osc_rise[1] : osc_rise[0];
  assign backup_edge = osc_rise[2];

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] div_sel;
  clk_state_e state;
  logic stop_eff;

  assign stop_eff = sg_on && converter_control_reg[`OSC_STOP_BIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      converter_control_reg <= `CONV_CTRL_RESET;
    end else if (req.wr && req.addr == `ADDR_CONV_CTRL) begin
      converter_control_reg <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_sel <= `DIV_CTRL_RESET;
    end else if (req.wr && req.addr == `ADDR_DIV_CTRL) begin
      div_sel <= req.wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `ADDR_CONV_CTRL: rdata <= converter_control_reg;
        `ADDR_STATUS: begin
          rdata <= 8'h00;
          rdata[`STAT_ON_BACKUP] <= on_backup;
          rdata[`STAT_MAIN_RUN] <= (state == ST_RUN_MAIN);
          rdata[`STAT_STARTING] <= (state == ST_STARTING);
          rdata[`STAT_SG_ON] <= sg_on;
        end
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // spike filter

  logic [3:0] gap_cnt;
  logic main_edge;

  assign main_edge = main_raw_edge && (!sg_on || gap_cnt >= 4'(SG_MIN));

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_cnt <= 4'hF;
    end else if (main_edge) begin
      gap_cnt <= 4'h1;
    end else if (gap_cnt != 4'hF) begin
      gap_cnt <= gap_cnt + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // missing edge timeout

  logic [7:0] miss_cnt;
  logic missing;

  assign missing = sg_on && (miss_cnt >= 8'(BACKUP_TIMEOUT));

  always_ff @(posedge mclk) begin
    if (rst) begin
      miss_cnt <= 8'h00;
    end else if (main_edge || state != ST_RUN_MAIN) begin
      miss_cnt <= 8'h00;
    end else if (!missing) begin
      miss_cnt <= miss_cnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // startup delay

  logic [15:0] start_cnt;
  logic main_seen;
  logic count_edge;
  logic delay_done;
  logic [15:0] start_last;

  assign start_last = long_delay ? 16'(STARTUP_LONG - 1) : 16'(STARTUP_SHORT - 1);
  assign count_edge = main_seen ? main_edge : (sg_on && backup_edge);
  assign delay_done = (start_cnt >= start_last) && main_seen;

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_cnt <= 16'h0000;
      main_seen <= 1'b0;
    end else if (state != ST_STARTING) begin
      start_cnt <= 16'h0000;
      main_seen <= 1'b0;
    end else begin
      if (main_edge) begin
        main_seen <= 1'b1;
      end
      if (count_edge && start_cnt < start_last) begin
        start_cnt <= start_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      por_delay_done <= 1'b0;
    end else if (state == ST_RUN_MAIN) begin
      por_delay_done <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // source state machine

  clk_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_STARTING: begin
        if (stop_eff) begin
          next_state = ST_RUN_BACKUP;
        end else if (delay_done) begin
          next_state = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (stop_eff) begin
          next_state = ST_RUN_BACKUP;
        end else if (cpu_tick) begin
          next_state = ST_RUN_MAIN;
        end
      end
      ST_RUN_MAIN: begin
        if (stop_eff || missing) begin
          next_state = ST_RUN_BACKUP;
        end
      end
      ST_RUN_BACKUP: begin
        if (!stop_eff) begin
          next_state = ST_STARTING;
        end
      end
      default: next_state = ST_STARTING;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_STARTING;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      main_osc_en <= 1'b1;
      backup_osc_en <= 1'b0;
      on_backup <= 1'b0;
    end else begin
      main_osc_en <= !stop_eff;
      backup_osc_en <= sg_on && next_state != ST_RUN_MAIN;
      on_backup <= sg_on && next_state != ST_RUN_MAIN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal clock and dividers

  logic src_edge;
  logic src_raw;
  logic [1:0] src_gap;

  // sources change only between edge pulses, and a switch never squeezes two edges
  assign src_raw = on_backup ? backup_edge : main_edge;
  assign src_edge = src_raw && (!sg_on || src_gap == 2'h3);

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_gap <= 2'h3;
    end else if (src_edge) begin
      src_gap <= 2'h1;
    end else if (src_gap != 2'h3) begin
      src_gap <= src_gap + 2'h1;
    end
  end

  tick_divider #(.W(4)) u_prescale (
    .mclk(mclk),
    .rst(rst),
    .en(src_edge),
    .ratio(decode_ratio(div_sel)),
    .tick(int_tick)
  );

  tick_divider #(.W(4)) u_periph_div (
    .mclk(mclk),
    .rst(rst),
    .en(int_tick),
    .ratio(4'(`PERIPH_DIVIDE)),
    .tick(periph_tick)
  );

  tick_divider #(.W(4)) u_cpu_div (
    .mclk(mclk),
    .rst(rst),
    .en(int_tick),
    .ratio(4'(`CPU_DIVIDE)),
    .tick(cpu_tick)
  );

endmodule : clock_safeguard

// [clock_safeguard_checker.sv]
// port assertions for clock_safeguard
// assumes one mclk domain, bound below
`timescale 1ns/1ps
module clock_safeguard_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire clock_safeguard_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  // outputs and strap
  input wire logic main_osc_en,
  input wire logic backup_osc_en,
  input wire logic safeguard_enable_option,
  input wire logic [7:0] converter_control_reg,
  input wire logic int_tick,
  input wire logic cpu_tick,
  input wire logic periph_tick,
  input wire logic on_backup
);
  import clock_safeguard_pkg::*;
  logic [3:0] ci;
  logic [3:0] pi;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // int ticks since last cpu tick
  always_ff @(posedge mclk) begin
    if (rst || cpu_tick)
      ci <= {3'h0, int_tick};
    else
      ci <= ci + {3'h0, int_tick};
  end
  // int ticks since last periph tick
  always_ff @(posedge mclk) begin
    if (rst || periph_tick)
      pi <= {3'h0, int_tick};
    else
      pi <= pi + {3'h0, int_tick};
  end
  ////////////////////////////////////////
  sequence s_d1_wr;
    req.wr && req.addr == 8'hD1;
  endsequence
  property p_stop;
    s_d1_wr ##0 req.wdata[2] && safeguard_enable_option |-> ##2 !main_osc_en && on_backup;
  endproperty
  property p_run;
    s_d1_wr ##0 !req.wdata[2] |-> ##2 main_osc_en;
  endproperty
  property p_ctrl;
    s_d1_wr |=> converter_control_reg == $past(req.wdata);
  endproperty
  property p_wo;
    req.rd && req.addr == 8'hDC |=> rdata == 8'h00;
  endproperty
  property p_cpu;
    cpu_tick |-> ci == 4'hD;
  endproperty
  property p_per;
    periph_tick |-> pi == 4'hC;
  endproperty
  property p_gap;
    safeguard_enable_option && int_tick |=> !int_tick [*2];
  endproperty
  property p_bk;
    on_backup |-> backup_osc_en;
  endproperty
  property p_nosg;
    !safeguard_enable_option [*6] |-> !on_backup && main_osc_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  a_run: assert property (p_run) else $error("main not restarted");
  a_ctrl: assert property (p_ctrl) else $error("D1 not written");
  a_wo: assert property (p_wo) else $error("DC readable");
  a_cpu: assert property (p_cpu) else $error("cpu ratio wrong");
  a_per: assert property (p_per) else $error("periph ratio wrong");
  a_gap: assert property (p_gap) else $error("ticks too close");
  a_bk: assert property (p_bk) else $error("backup source off");
  a_nosg: assert property (p_nosg) else $error("backup used");
endmodule : clock_safeguard_checker

bind clock_safeguard clock_safeguard_checker u_clock_safeguard_checker (
  .mclk(mclk),
  .rst(rst),
  .req(req),
  .rdata(rdata),
  .main_osc_en(main_osc_en),
  .backup_osc_en(backup_osc_en),
  .safeguard_enable_option(safeguard_enable_option),
  .converter_control_reg(converter_control_reg),
  .int_tick(int_tick),
  .cpu_tick(cpu_tick),
  .periph_tick(periph_tick),
  .on_backup(on_backup)
);

// [testbench.sv]
// self-checking bench for clock_safeguard
// assumes the checker file binds itself
`timescale 1ns/1ps
module testbench;
  import clock_safeguard_pkg::*;
  logic mclk, rst, xtal, rc, bko, moe, boe, sgo, typ, dly, it, ct, pt, onb, pdd, osc, xrun;
  reg_req_s req;
  logic [7:0] rdata, ccr;
  int hp, xc, bc, xe, cyc, err_count, n_checks;
  clock_safeguard #(.STARTUP_SHORT(8), .STARTUP_LONG(64)) u_clock_safeguard (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .xtal_osc_in(xtal),
    .rc_osc_in(rc), .backup_osc_in(bko), .main_osc_en(moe), .backup_osc_en(boe),
    .safeguard_enable_option(sgo), .osc_type_option(typ), .delay_option(dly),
    .converter_control_reg(ccr), .int_tick(it), .cpu_tick(ct), .periph_tick(pt),
    .on_backup(onb), .por_delay_done(pdd)
  );
  initial begin
    mclk = 1'h0;
    forever #25 mclk = !mclk;
  end
  assign xtal = osc & !typ;
  assign rc = osc & typ;
  // oscillators run only while enabled; cycle ceiling
  always @(posedge mclk) begin
    if (xrun && moe && ++xc >= hp) begin
      xc = 0;
      osc <= !osc;
      xe += !osc;
    end
    if (boe && ++bc >= 20) begin
      bc = 0;
      bko <= !bko;
    end
    if (++cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req <= '{a, d, 1'h1, 1'h0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge mclk);
    req <= '0;
    #1 chk("rdata", e, rdata);
    @(posedge mclk);
  endtask : rd
  task automatic tk;
    do @(posedge mclk); while (it !== 1'h1);
  endtask : tk
  task automatic gap(int e);
    int n;
    tk();
    tk();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (it !== 1'h1);
    chk("gap", 8'(e), 8'(n));
  endtask : gap
  task automatic rs(logic s, logic t, logic d);
    rst <= 1'h1;
    sgo <= s;
    typ <= t;
    dly <= d;
    @(posedge mclk);
    #1 xe = 0;
    @(posedge mclk);
    rst <= 1'h0;
    do @(posedge mclk); while (pdd !== 1'h1);
    repeat (2) @(posedge mclk);
  endtask : rs
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial begin
    req = '0;
    rst = 1'h1;
    osc = 1'h0;
    bko = 1'h0;
    xrun = 1'h1;
    sgo = 1'h1;
    typ = 1'h0;
    dly = 1'h0;
    hp = 4;
    xc = 0;
    bc = 0;
    xe = 0;
    cyc = 0;
    err_count = 0;
    n_checks = 0;
    @(posedge mclk);
    rs(1'h1, 1'h0, 1'h0);
    chk("por", 8'h01, 8'(xe >= 8));
    chk("onb", 8'h00, 8'(onb));
    chk("boe", 8'h00, 8'(boe));
    rd(8'hD1, 8'h00);
    wr(8'hD1, 8'hFB);
    rd(8'hD1, 8'hFB);
    chk("moe", 8'h01, 8'(moe));
    wr(8'hDC, 8'hFF);
    rd(8'hDC, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'hDF, 8'h0A);
    for (int i = 0; i < 4; i++) begin
      wr(8'hDC, 8'(i));
      gap(i == 0 ? 8 : i == 1 ? 16 : 32);
    end
    wr(8'hDC, 8'h00);
    hp = 1;
    gap(4);
    hp = 4;
    $display("test registers and ratio done");
    wr(8'hD1, 8'h04);
    repeat (2) @(posedge mclk);
    chk("moe", 8'h00, 8'(moe));
    chk("onb", 8'h01, 8'(onb));
    rd(8'hDF, 8'h09);
    gap(40);
    wr(8'hD1, 8'h00);
    repeat (2) @(posedge mclk);
    chk("moe", 8'h01, 8'(moe));
    chk("onb", 8'h01, 8'(onb));
    do @(posedge mclk); while (onb !== 1'h0);
    @(posedge mclk);
    chk("boe", 8'h00, 8'(boe));
    $display("test stop and restart done");
    xrun = 1'h0;
    repeat (20) @(posedge mclk);
    chk("onb", 8'h00, 8'(onb));
    repeat (40) @(posedge mclk);
    chk("onb", 8'h01, 8'(onb));
    xrun = 1'h1;
    do @(posedge mclk); while (onb !== 1'h0);
    chk("moe", 8'h01, 8'(moe));
    $display("test missing edge done");
    rs(1'h0, 1'h1, 1'h1);
    chk("por", 8'h01, 8'(xe >= 63));
    gap(8);
    rd(8'hDF, 8'h02);
    wr(8'hD1, 8'h04);
    repeat (2) @(posedge mclk);
    chk("moe", 8'h01, 8'(moe));
    chk("onb", 8'h00, 8'(onb));
    $display("test options done");
    summarize();
  end
endmodule : testbench
